// >>> cio_consts.svh
// Register offsets, field positions, masks and reset values for the I/O block
`ifndef CIO_CONSTS_SVH
`define CIO_CONSTS_SVH

`define CIO_ADDR_W          8
`define CIO_OFF_PIN_DIR     8'h00
`define CIO_OFF_PIN_LEVEL   8'h04
`define CIO_OFF_PIN_OP      8'h08
`define CIO_OFF_GP_DIR      8'h0C
`define CIO_OFF_GP_TRIS     8'h10
`define CIO_OFF_GP_LEVEL    8'h14
`define CIO_OFF_GP_LEVEL2   8'h18
`define CIO_OFF_GP_OP       8'h1C
`define CIO_OFF_GP_SPECIAL  8'h20
`define CIO_OFF_PIN_IN      8'h24
`define CIO_OFF_ANALOG_IN   8'h28
`define CIO_OFF_STATUS      8'h2C

// Eight-pin variant: fixed pins and selectable mask
`define CIO_FIXED_OUT_BIT   0
`define CIO_FIXED_IN_BIT    3
`define CIO_PIN_SEL_MASK    8'h16
`define CIO_PIN_DIR_RST     8'h01

// General port resets: all inputs; every port level resets low
`define CIO_GP_DIR_RST      8'h00
`define CIO_LEVEL_RST       8'h00

// Operation field layout: [2:0] pin/bit, [6:4] opcode
`define CIO_OP_BIT_LSB      0
`define CIO_OP_CODE_LSB     4

// Special function enable bits
`define CIO_SF_IR           0
`define CIO_SF_PWM          1
`define CIO_SF_TWI          2
`define CIO_SF_KBD          3

// Status bits
`define CIO_ST_ANALOG_BUSY  0
`define CIO_ST_DOWNLOAD     1

`endif

// >>> cio_pkg.sv
// Types shared by the configurable I/O block
package cio_pkg;

    typedef enum logic [2:0] {
        CIO_OP_NONE   = 3'b000,
        CIO_OP_HIGH   = 3'b001,
        CIO_OP_LOW    = 3'b010,
        CIO_OP_TOGGLE = 3'b011,
        CIO_OP_OUTPUT = 3'b100,
        CIO_OP_INPUT  = 3'b101,
        CIO_OP_STREAM = 3'b110,
        CIO_OP_ANALOG = 3'b111
    } cio_op_e;

    typedef enum logic [1:0] {
        CIO_BUS_IDLE  = 2'b00,
        CIO_BUS_RESP  = 2'b01
    } cio_bus_e;

endpackage

// >>> cio_reg_if.sv
// Register write and read strobes between the bus slave and the pin logic
`timescale 1ns/1ps
`default_nettype none
interface cio_reg_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [7:0]  rd_addr;
    modport slave (output wr_en, output wr_addr, output wr_data,
                   output wr_strb, output rd_addr);
    modport core  (input wr_en, input wr_addr, input wr_data,
                   input wr_strb, input rd_addr);
endinterface
`default_nettype wire

// >>> cio_axil_slave.sv
// AXI4-Lite slave front end: takes writes and reads, hands them on as strobes
`timescale 1ns/1ps
`default_nettype none
module cio_axil_slave
    import cio_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    input  wire logic [7:0]  araddr_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    cio_reg_if.slave         regs
);
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    cio_bus_e    wr_state;
    cio_bus_e    rd_state;
    logic [7:0]  rd_hold;

    // Address and data are latched in either order, then one write strobe
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= 8'h00;
            w_data   <= 32'h0000_0000;
            w_strb   <= 4'h0;
            wr_state <= CIO_BUS_IDLE;
            bvalid_o <= 1'b0;
        end else begin
            case (wr_state)
                CIO_BUS_IDLE: begin
                    if (awvalid_i && !aw_held) begin
                        aw_held <= 1'b1;
                        aw_addr <= awaddr_i;
                    end
                    if (wvalid_i && !w_held) begin
                        w_held <= 1'b1;
                        w_data <= wdata_i;
                        w_strb <= wstrb_i;
                    end
                    if (aw_held && w_held) begin
                        wr_state <= CIO_BUS_RESP;
                        bvalid_o <= 1'b1;
                    end
                end
                default: begin
                    if (bready_i) begin
                        bvalid_o <= 1'b0;
                        aw_held  <= 1'b0;
                        w_held   <= 1'b0;
                        wr_state <= CIO_BUS_IDLE;
                    end
                end
            endcase
        end
    end

    assign awready_o     = !aw_held && (wr_state == CIO_BUS_IDLE);
    assign wready_o      = !w_held && (wr_state == CIO_BUS_IDLE);
    assign regs.wr_en    = aw_held && w_held && (wr_state == CIO_BUS_IDLE);
    assign regs.wr_addr  = aw_addr;
    assign regs.wr_data  = w_data;
    assign regs.wr_strb  = w_strb;

    // Read: core decodes the address being taken, so data meets rvalid
    assign regs.rd_addr = (rd_state == CIO_BUS_IDLE) ? araddr_i : rd_hold;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_state <= CIO_BUS_IDLE;
            rvalid_o <= 1'b0;
            rd_hold  <= 8'h00;
        end else begin
            case (rd_state)
                CIO_BUS_IDLE: begin
                    if (arvalid_i) begin
                        rd_hold      <= araddr_i;
                        rvalid_o     <= 1'b1;
                        rd_state     <= CIO_BUS_RESP;
                    end
                end
                default: begin
                    if (rready_i) begin
                        rvalid_o <= 1'b0;
                        rd_state <= CIO_BUS_IDLE;
                    end
                end
            endcase
        end
    end

    assign arready_o = (rd_state == CIO_BUS_IDLE);
endmodule
`default_nettype wire

// >>> cio_port_top.sv
// Pin direction and port function logic for the eight-pin and 28-pin variants
//
// Operation
// - Pin 0 always output, pin 3 input
// - Selectable pins start as inputs
// - Output-type operations make pin an output
// - Drive-low makes output and forces low
// - Set-as-output changes direction only
// - Direction operations ignore fixed pins 0, 3
// - Direction mask write sets all selectable directions
// - Mask bits 0,3,5,6,7 are ignored
// - Analogue read makes pin 1 analogue input
// - Shared port: four inputs, never outputs
// - Eight fixed outputs, direction never changes
// - General port: eight pins, inputs at reset
// - General port pins carry special functions
// - Shared port digital reads are plain levels
// - Single-bit drive makes output, sets level
// - General direction mask: 1 output, 0 input
// - Tristate mask inverted: 1 input, 0 output
// - Level write drives all output pins except general bits 1, 2 while PWM is on and pin 0 while download is active
// - Pin 0 carries download serial output
`include "cio_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cio_port_top
    import cio_pkg::*;
#(
    parameter int PIN_W  = 5,
    parameter int GP_W   = 8,
    parameter int AN_W   = 4
) (
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic [7:0]       awaddr_i,
    input  wire logic             awvalid_i,
    output logic                  awready_o,
    input  wire logic [31:0]      wdata_i,
    input  wire logic [3:0]       wstrb_i,
    input  wire logic             wvalid_i,
    output logic                  wready_o,
    output logic [1:0]            bresp_o,
    output logic                  bvalid_o,
    input  wire logic             bready_i,
    input  wire logic [7:0]       araddr_i,
    input  wire logic             arvalid_i,
    output logic                  arready_o,
    output logic [31:0]           rdata_o,
    output logic [1:0]            rresp_o,
    output logic                  rvalid_o,
    input  wire logic             rready_i,
    input  wire logic [PIN_W-1:0] pin_in_i,
    output logic [PIN_W-1:0]      pin_out_o,
    output logic [PIN_W-1:0]      pin_oe_o,
    output logic                  pin1_analog_o,
    input  wire logic             download_active_i,
    input  wire logic             download_txd_i,
    input  wire logic             stream_bit_i,
    input  wire logic [AN_W-1:0]  shared_in_i,
    output logic [AN_W-1:0]       shared_analog_o,
    output logic [GP_W-1:0]       fixed_output_port_o,
    input  wire logic [GP_W-1:0]  gp_in_i,
    output logic [GP_W-1:0]       gp_out_o,
    output logic [GP_W-1:0]       gp_oe_o,
    output logic [3:0]            gp_special_o,
    output logic                  ir_rx_o,
    output logic                  twi_scl_o,
    output logic                  twi_sda_o,
    output logic                  kbd_clk_o,
    output logic                  kbd_data_o
);
    cio_reg_if regs ();

    logic [PIN_W-1:0] pin_dir;
    logic [PIN_W-1:0] pin_level;
    logic             pin1_adc;
    logic [GP_W-1:0]  gp_dir;
    logic [GP_W-1:0]  gp_level;
    logic [GP_W-1:0]  fixed_level;
    logic [3:0]       special_en;
    logic [31:0]      next_rdata;
    logic             bad_wr;
    logic             bad_rd;
    cio_op_e          pin_op;
    cio_op_e          gp_op;
    logic [2:0]       op_bit;
    logic [PIN_W-1:0] op_onehot;
    logic [GP_W-1:0]  gp_onehot;

    // Decode used for both write and read legality
    function automatic logic is_mapped(input logic [7:0] a);
        if (a[1:0] == 2'b00 && a <= `CIO_OFF_STATUS) is_mapped = 1'b1;
        else                                         is_mapped = 1'b0;
    endfunction

    cio_axil_slave u_slave (
        .clock_i   (clock_i),
        .rstn_i    (rstn_i),
        .awaddr_i  (awaddr_i),
        .awvalid_i (awvalid_i),
        .awready_o (awready_o),
        .wdata_i   (wdata_i),
        .wstrb_i   (wstrb_i),
        .wvalid_i  (wvalid_i),
        .wready_o  (wready_o),
        .bvalid_o  (bvalid_o),
        .bready_i  (bready_i),
        .araddr_i  (araddr_i),
        .arvalid_i (arvalid_i),
        .arready_o (arready_o),
        .rvalid_o  (rvalid_o),
        .rready_i  (rready_i),
        .regs      (regs)
    );

    // Low byte lane gates every write except the fixed-output level, which uses lane 1
    logic wr_lo;
    assign wr_lo  = regs.wr_en && regs.wr_strb[0];
    assign op_bit = regs.wr_data[`CIO_OP_BIT_LSB +: 3];
    assign pin_op = cio_op_e'(regs.wr_data[`CIO_OP_CODE_LSB +: 3]);
    assign gp_op  = pin_op;

    // One-hot of the addressed pin, limited to real pins
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_pin_hot
            assign op_onehot[gi] = (op_bit == 3'(gi));
        end
        for (gi = 0; gi < GP_W; gi++) begin : g_gp_hot
            assign gp_onehot[gi] = (op_bit == 3'(gi));
        end
    endgenerate

    // Eight-pin direction: fixed bits masked out of every change
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_dir <= PIN_W'(`CIO_PIN_DIR_RST);
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_PIN_DIR) begin
            pin_dir <= (regs.wr_data[PIN_W-1:0] & PIN_W'(`CIO_PIN_SEL_MASK))
                     | PIN_W'(`CIO_PIN_DIR_RST);
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_PIN_OP) begin
            case (pin_op)
                CIO_OP_HIGH, CIO_OP_LOW, CIO_OP_TOGGLE,
                CIO_OP_STREAM, CIO_OP_OUTPUT: begin
                    // Fixed input pin is outside the mask, so stays input
                    pin_dir <= pin_dir
                             | (op_onehot & PIN_W'(`CIO_PIN_SEL_MASK));
                end
                CIO_OP_INPUT: begin
                    pin_dir <= pin_dir
                             & ~(op_onehot & PIN_W'(`CIO_PIN_SEL_MASK));
                end
                CIO_OP_ANALOG: begin
                    if (op_bit == 3'd1) begin
                        pin_dir[1] <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Eight-pin levels: set-as-output leaves the level alone
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_level <= PIN_W'(`CIO_LEVEL_RST);
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_PIN_LEVEL) begin
            pin_level <= regs.wr_data[PIN_W-1:0];
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_PIN_OP) begin
            case (pin_op)
                CIO_OP_HIGH:   pin_level <= pin_level | op_onehot;
                CIO_OP_LOW:    pin_level <= pin_level & ~op_onehot;
                CIO_OP_TOGGLE: pin_level <= pin_level ^ op_onehot;
                default:       pin_level <= pin_level;
            endcase
        end
    end

    // Analogue mode of pin 1 follows the last read or direction change
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin1_adc <= 1'b0;
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_PIN_OP
                     && op_bit == 3'd1) begin
            pin1_adc <= (pin_op == CIO_OP_ANALOG);
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_PIN_DIR
                     && regs.wr_data[1]) begin
            pin1_adc <= 1'b0;
        end
    end

    // General port direction: plain mask, inverted mask, single bit or PWM enable (bits 1, 2)
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gp_dir <= GP_W'(`CIO_GP_DIR_RST);
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_GP_DIR) begin
            gp_dir <= regs.wr_data[GP_W-1:0];
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_GP_TRIS) begin
            gp_dir <= ~regs.wr_data[GP_W-1:0];
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_GP_OP) begin
            case (gp_op)
                CIO_OP_HIGH, CIO_OP_LOW, CIO_OP_TOGGLE,
                CIO_OP_OUTPUT:  gp_dir <= gp_dir | gp_onehot;
                CIO_OP_INPUT:   gp_dir <= gp_dir & ~gp_onehot;
                default:        gp_dir <= gp_dir;
            endcase
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_GP_SPECIAL
                     && regs.wr_data[`CIO_SF_PWM]) begin
            gp_dir[2:1] <= 2'b11;
        end
    end

    // General port levels: both aliases store the same byte
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gp_level <= GP_W'(`CIO_LEVEL_RST);
        end else if (wr_lo && (regs.wr_addr == `CIO_OFF_GP_LEVEL
                     || regs.wr_addr == `CIO_OFF_GP_LEVEL2)) begin
            gp_level <= regs.wr_data[GP_W-1:0];
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_GP_OP) begin
            case (gp_op)
                CIO_OP_HIGH:   gp_level <= gp_level | gp_onehot;
                CIO_OP_LOW:    gp_level <= gp_level & ~gp_onehot;
                CIO_OP_TOGGLE: gp_level <= gp_level ^ gp_onehot;
                default:       gp_level <= gp_level;
            endcase
        end
    end

    // Fixed-output port: level only, direction is hard-wired
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fixed_level <= GP_W'(`CIO_LEVEL_RST);
        end else if (regs.wr_en && regs.wr_strb[1]
                     && regs.wr_addr == `CIO_OFF_PIN_LEVEL) begin
            fixed_level <= regs.wr_data[8 +: GP_W];
        end
    end

    // Special function enables
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            special_en <= 4'h0;
        end else if (wr_lo && regs.wr_addr == `CIO_OFF_GP_SPECIAL) begin
            special_en <= regs.wr_data[3:0];
        end
    end

    // Pin drive: download serial overrides pin 0 while active
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_out_o <= PIN_W'(`CIO_LEVEL_RST);
            pin_oe_o  <= PIN_W'(`CIO_PIN_DIR_RST);
            pin1_analog_o <= 1'b0;
        end else begin
            pin_out_o <= pin_level;
            if (download_active_i) begin
                pin_out_o[`CIO_FIXED_OUT_BIT] <= download_txd_i;
            end else if (pin_dir[1] == 1'b0 && pin1_adc) begin
                pin_out_o[1] <= 1'b0;
            end
            pin_oe_o  <= pin_dir;
            pin1_analog_o <= pin1_adc && !pin_dir[1];
        end
    end

    // General port drive, PWM outputs replace levels on bits 1 and 2
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gp_out_o <= GP_W'(`CIO_LEVEL_RST);
            gp_oe_o  <= GP_W'(`CIO_GP_DIR_RST);
            gp_special_o <= 4'h0;
            fixed_output_port_o <= GP_W'(`CIO_LEVEL_RST);
            shared_analog_o <= '1;
        end else begin
            gp_out_o <= gp_level;
            if (special_en[`CIO_SF_PWM]) begin
                gp_out_o[1] <= stream_bit_i;
                gp_out_o[2] <= stream_bit_i;
            end
            gp_oe_o  <= gp_dir;
            gp_special_o <= special_en;
            fixed_output_port_o <= fixed_level;
            shared_analog_o <= '1;
        end
    end

    // Special function inputs, gated by their enables
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ir_rx_o    <= 1'b0;
            twi_scl_o  <= 1'b0;
            twi_sda_o  <= 1'b0;
            kbd_clk_o  <= 1'b0;
            kbd_data_o <= 1'b0;
        end else begin
            ir_rx_o    <= special_en[`CIO_SF_IR]  & gp_in_i[0];
            twi_scl_o  <= special_en[`CIO_SF_TWI] & gp_in_i[3];
            twi_sda_o  <= special_en[`CIO_SF_TWI] & gp_in_i[4];
            kbd_clk_o  <= special_en[`CIO_SF_KBD] & gp_in_i[6];
            kbd_data_o <= special_en[`CIO_SF_KBD] & gp_in_i[7];
        end
    end

    // Read mux; fixed pins read back their fixed direction
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (regs.rd_addr == `CIO_OFF_PIN_DIR) begin
            next_rdata[PIN_W-1:0] = pin_dir;
        end else if (regs.rd_addr == `CIO_OFF_PIN_LEVEL) begin
            next_rdata[PIN_W-1:0] = pin_level;
            next_rdata[8 +: GP_W] = fixed_level;
        end else if (regs.rd_addr == `CIO_OFF_GP_DIR) begin
            next_rdata[GP_W-1:0] = gp_dir;
        end else if (regs.rd_addr == `CIO_OFF_GP_TRIS) begin
            next_rdata[GP_W-1:0] = ~gp_dir;
        end else if (regs.rd_addr == `CIO_OFF_GP_LEVEL
                     || regs.rd_addr == `CIO_OFF_GP_LEVEL2) begin
            next_rdata[GP_W-1:0] = gp_level;
        end else if (regs.rd_addr == `CIO_OFF_GP_SPECIAL) begin
            next_rdata[3:0] = special_en;
        end else if (regs.rd_addr == `CIO_OFF_PIN_IN) begin
            next_rdata[PIN_W-1:0] = pin_in_i;
            next_rdata[8 +: GP_W] = gp_in_i;
        end else if (regs.rd_addr == `CIO_OFF_ANALOG_IN) begin
            next_rdata[AN_W-1:0] = shared_in_i;
        end else if (regs.rd_addr == `CIO_OFF_STATUS) begin
            next_rdata[`CIO_ST_ANALOG_BUSY] = pin1_adc;
            next_rdata[`CIO_ST_DOWNLOAD]    = download_active_i;
        end
    end

    assign bad_wr = !is_mapped(regs.wr_addr);
    assign bad_rd = !is_mapped(regs.rd_addr);

    // Read data and responses registered; unmapped answers SLVERR
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 32'h0000_0000;
            rresp_o <= 2'b00;
            bresp_o <= 2'b00;
        end else begin
            if (arvalid_i && arready_o) begin
                rdata_o <= next_rdata;
                rresp_o <= bad_rd ? 2'b10 : 2'b00;
            end
            if (regs.wr_en) begin
                bresp_o <= bad_wr ? 2'b10 : 2'b00;
            end
        end
    end
endmodule
`default_nettype wire

// >>> cio_port_sva.sv
// Concurrent checks on the I/O block's top-level ports
`timescale 1ns/1ps
`default_nettype none
module cio_port_sva (
    input wire logic       clock_i,
    input wire logic       rstn_i,
    input wire logic       awvalid_i,
    input wire logic       awready_o,
    input wire logic       wvalid_i,
    input wire logic       wready_o,
    input wire logic       bvalid_o,
    input wire logic       bready_i,
    input wire logic       arvalid_i,
    input wire logic       arready_o,
    input wire logic       rvalid_o,
    input wire logic       rready_i,
    input wire logic [4:0] pin_oe_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // Fixed pins must hold whatever software writes to the mask
    a_fixed_pin_dirs: assert property (pin_oe_o[0] && !pin_oe_o[3])
        else $error("fixed pin direction lost");
    // Write answers two edges after both halves are taken, read one edge
    a_write_answer: assert property (awvalid_i && awready_o && wvalid_i &&
        wready_o |-> ##2 bvalid_o) else $error("write response late");
    a_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
        else $error("read response late");
    // Answers stand until taken, then drop
    a_bvalid_stand: assert property (bvalid_o && !bready_i |=> bvalid_o)
        else $error("write response dropped");
    a_rvalid_stand: assert property (rvalid_o && !rready_i |=> rvalid_o)
        else $error("read response dropped");
    a_bvalid_single: assert property (bvalid_o && bready_i |=> !bvalid_o)
        else $error("write response repeated");
    a_rvalid_single: assert property (rvalid_o && rready_i |=> !rvalid_o)
        else $error("read response repeated");
    // A pending response blocks a new write, so writes never overlap
    a_write_refused: assert property (bvalid_o |-> !awready_o && !wready_o)
        else $error("write taken while busy");
endmodule
`default_nettype wire

// >>> cio_ext_model.sv
// Switches and loads hanging on the eight-pin and general ports
`timescale 1ns/1ps
`default_nettype none
module cio_ext_model (
    input  wire logic [4:0] pin_out_i,
    input  wire logic [4:0] pin_oe_i,
    input  wire logic [7:0] gp_out_i,
    input  wire logic [7:0] gp_oe_i,
    input  wire logic [4:0] sw_pin_i,
    input  wire logic [7:0] sw_gp_i,
    output logic      [4:0] pin_in_o,
    output logic      [7:0] gp_in_o
);
    // A driven pin reads back its own level, otherwise the switch wins
    assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & sw_pin_i);
    assign gp_in_o  = (gp_oe_i & gp_out_i) | (~gp_oe_i & sw_gp_i);
endmodule
`default_nettype wire

// >>> cio_port_top_tb.sv
// Self-checking bench for the configurable I/O block
`timescale 1ns/1ps
`default_nettype none
module cio_port_top_tb;
    logic        clock_i = 1'h0, rstn_i = 1'h0, stream_bit_i = 1'h0;
    logic        awvalid_i = 1'h0, wvalid_i = 1'h0, bready_i = 1'h0;
    logic        arvalid_i = 1'h0, rready_i = 1'h0;
    logic        download_active_i = 1'h0, download_txd_i = 1'h0;
    logic [7:0]  awaddr_i = 8'h00, araddr_i = 8'h00, sw_gp = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic [33:0] x;
    logic [3:0]  wstrb_i = 4'hF, shared_in_i = 4'h0;
    logic [3:0]  shared_analog_o, gp_special_o;
    logic [1:0]  bresp_o, rresp_o;
    logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
    logic        pin1_analog_o, ir_rx_o, twi_scl_o, twi_sda_o;
    logic        kbd_clk_o, kbd_data_o;
    logic [4:0]  pin_out_o, pin_oe_o;
    wire  [4:0]  pin_in_i;
    logic [7:0]  fixed_output_port_o, gp_out_o, gp_oe_o;
    wire  [7:0]  gp_in_i;
    int          failures = 0, samples_checked = 0, cycles = 0;
    // Steps as {offset, data, expected direction and driven level}
    logic [31:0] pin_tab [9] = '{32'h084200A4, 32'h082200A0, 32'h081402B0,
        32'h083402A0, 32'h08520220, 32'h08610260, 32'h08500260,
        32'h08430260, 32'h08710220};
    logic [31:0] gp_tab [7] = '{32'h0CFFFF00, 32'h18A5FFA5, 32'h143CFF3C,
        32'h10F00F0C, 32'h0C000000, 32'h1C164040, 32'h1C224440};

    cio_port_top cio_port_top_inst (.*);
    cio_ext_model cio_ext_model_inst (.pin_out_i(pin_out_o),
        .pin_oe_i(pin_oe_o), .gp_out_i(gp_out_o), .gp_oe_i(gp_oe_o),
        .sw_pin_i(5'h08), .sw_gp_i(sw_gp), .pin_in_o(pin_in_i),
        .gp_in_o(gp_in_i));

    always #2 clock_i = ~clock_i;
    // Timeout far above the run's length
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures++;
            stop_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask

    // Sampled at the falling edge, driven just after the rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge clock_i);
        {awaddr_i, wdata_i} <= {a, d};
        {awvalid_i, wvalid_i, bready_i} <= 3'h7;
        do begin
            @(negedge clock_i);
            {aw, w, b} = {awready_o, wready_o, bvalid_o};
            @(posedge clock_i);
            if (aw) awvalid_i <= 1'h0;
            if (w) wvalid_i <= 1'h0;
        end while (!b);
        bready_i <= 1'h0;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
    endtask

    // Read data is taken at the edge where rvalid is seen high
    task automatic rd(input logic [7:0] a);
        logic ar, go;
        @(posedge clock_i);
        araddr_i <= a;
        {arvalid_i, rready_i} <= 2'h3;
        do begin
            @(negedge clock_i);
            {ar, go, x} = {arready_o, rvalid_o, rresp_o, rdata_o};
            @(posedge clock_i);
            if (ar) arvalid_i <= 1'h0;
        end while (!go);
        rready_i <= 1'h0;
    endtask

    task automatic play(input logic [31:0] st, input logic gp);
        logic [15:0] ob;
        wr(st[31:24], {24'h0, st[23:16]});
        ob = gp ? {gp_oe_o, gp_out_o & gp_oe_o}
                : {6'h0, pin_oe_o, pin_out_o & pin_oe_o & 5'h1D};
        chk("port", ob, st[15:0]);
    endtask

    task automatic t_reset;
        chk("pin oe", pin_oe_o, 5'h01);
        chk("gp oe", gp_oe_o, 8'h00);
        chk("shared", shared_analog_o, 4'hF);
        rd(8'h00);
        chk("pin mask", x[31:0], 32'h01);
    endtask

    task automatic t_mask;
        wr(8'h00, 32'hFF);
        chk("pin oe", pin_oe_o, 5'h17);
        rd(8'h00);
        chk("pin mask", x[31:0], 32'h17);
        wr(8'h00, 32'hE8);
        chk("pin oe", pin_oe_o, 5'h01);
    endtask

    task automatic t_ops;
        wr(8'h04, 32'h5A04);
        chk("fixed port", fixed_output_port_o, 8'h5A);
        foreach (pin_tab[i]) play(pin_tab[i], 1'h0);
        chk("analog", pin1_analog_o, 1'h1);
        foreach (gp_tab[i]) play(gp_tab[i], 1'h1);
    endtask

    // Switches high on every special input, enables on then off
    task automatic t_special;
        @(posedge clock_i) sw_gp <= 8'hD9;
        for (int e = 1; e >= 0; e--) begin
            wr(8'h20, e ? 32'hF : 32'h0);
            if (e) chk("pwm dir", gp_oe_o[2:1], 2'h3);
            chk("special", {gp_special_o, ir_rx_o, twi_scl_o, twi_sda_o,
                kbd_clk_o, kbd_data_o}, e ? 32'h1FF : 32'h0);
        end
    endtask

    task automatic t_misc;
        @(posedge clock_i) shared_in_i <= 4'hA;
        rd(8'h28);
        chk("shared in", x[31:0], 32'hA);
        rd(8'h3C);
        chk("bad addr", x[33:32], 2'h2);
        download_active_i <= 1'h1;
        repeat (6) @(posedge clock_i) download_txd_i <= ~download_txd_i;
        @(negedge clock_i);
        chk("download", pin_out_o[0], !download_txd_i);
        @(posedge clock_i) download_active_i <= 1'h0;
    endtask

    task automatic stop_test;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'h1;
        @(posedge clock_i);
        t_reset();
        t_mask();
        t_ops();
        t_special();
        t_misc();
        stop_test();
    end
endmodule
bind cio_port_top cio_port_sva cio_port_sva_inst (.*);
`default_nettype wire
